// File: core/rcpl_pkg.sv
// Constants shared by the reset cause and pin lock block
package rcpl_pkg;
    // Register indices; byte address is four times the index
    localparam logic [13:0] IDX_CAUSE = 14'h0fcc;
    localparam logic [13:0] IDX_CTRL = 14'h0fde;
    localparam logic [13:0] IDX_KEY = 14'h0fdf;
    localparam logic [13:0] IDX_IRQ_STATUS = 14'h0fe0;
    localparam logic [13:0] IDX_IRQ_ENABLE = 14'h0fe1;
    localparam logic [13:0] IDX_IRQ_CLEAR = 14'h0fe2;
    // Key codes
    localparam logic [7:0] KEY_PIN = 8'hb2;
    localparam logic [7:0] KEY_REGION = 8'hd4;
    localparam logic [7:0] KEY_FLAGS = 8'h71;
    // Field positions
    localparam int CTRL_PIN_BIT = 0;
    localparam int CTRL_REGION_BIT = 1;
    localparam int CTRL_VECTOR_BIT = 2;
    localparam int CAUSE_CLEAR_BIT = 7;
    localparam int CAUSE_W = 7;
    localparam int CTRL_W = 3;
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 7'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage

// File: core/rcpl_top.sv
// Reset combiner with keyed pin-disable lock and sticky reset-cause flags
//
// What this block does
// R1 - Eight reset sources: pin, power-on, two voltage, watchdog, clock, trim, flash.
// R2 - Committed pin-disable 0 honours the reset pin, 1 ignores it.
// R3 - A written pin-disable value takes effect only after key 0xB2.
// R4 - Committed pin-disable cleared by power-on only; written copy by any reset.
// R5 - Key 0xB2 commits bit 0, 0xD4 bits 1-2, 0x71 flag clear; others ignored.
// R6 - Software writes the key register with plain writes only, never read-modify-write.
// R7 - Reading the key address returns committed bits 0 to 2 as status.
// R8 - Software writes keys in fast normal mode with gear select 00.
// R9 - Protected control bits 7 to 3 read as zero.
// R10 - One sticky cause flag per internal reset source, bit 5 bad trim.
// R11 - Cause flags cleared by power-on, pin reset or keyed clear only.
// R12 - Clear bit 7 then key 0x71 clears the clear bit and all flags of inactive sources.
// R13 - Cause register bit 7 always reads as zero.
// R14 - System reset held while any active source; internal resets set cause flags.
`timescale 1ns/1ps
module rcpl_top #(
    parameter int ADDR_W = 16
) (
    // Clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External reset pin, asynchronous, active low
    input wire logic reset_pin_n,
    // Internal reset sources and bad trim status, active high, on pclk
    input wire logic src_watchdog,
    input wire logic src_clock_fault,
    input wire logic src_voltage_one,
    input wire logic src_voltage_two,
    input wire logic src_trim_fault,
    input wire logic src_bad_trim,
    input wire logic src_flash_standby,
    // Combined reset and committed settings
    output logic sys_reset,
    output logic pin_disable_committed,
    output logic reset_region_committed,
    output logic reset_vector_committed,
    // Interrupt
    output logic irq
);

    // Register map, byte address is four times the index
    //   cause flags       index 0x0fcc, sticky flags plus clear request
    //   protected control index 0x0fde, written copy of the settings
    //   protection key    index 0x0fdf, key on write, status on read
    //   interrupt status  index 0x0fe0, read only
    //   interrupt enable  index 0x0fe1, read and write
    //   interrupt clear   index 0x0fe2, write one to clear, reads zero
    // Any other index, or an unaligned address, answers with an error
    // An error transfer reads zero and writes nothing
    // Only the low byte lane carries data; upper lanes read zero

    // Cause flag layout
    //   bit 0 watchdog
    //   bit 1 clock fault
    //   bit 2 voltage detect one
    //   bit 3 voltage detect two
    //   bit 4 trim fault
    //   bit 5 bad trim status, a flag but not a reset
    //   bit 6 flash standby
    //   bit 7 clear request, write only, reads zero

    // Protected control layout
    //   bit 0 pin disable
    //   bit 1 reset region select
    //   bit 2 reset vector select
    //   bits 7 to 3 read zero

    // Key values
    //   pin key commits bit 0
    //   region key commits bits 1 and 2
    //   flag key clears the causes when a clear request waits
    //   any other value leaves everything as it is

    // Bus timing
    //   zero wait states, ready tied high
    //   read data and error latched in the setup cycle
    //   read data stands until the next setup cycle
    //   writes land at the access edge
    //   committed bits move at the access edge of the key write
    //   back to back transfers need no idle cycle

    // Reset behaviour
    //   presetn is the power-on reset and clears everything
    //   committed bits survive pin and internal resets
    //   written copy is lost in any cycle with a reset pending
    //   pin reset also drops the clear request
    //   pin reset reloads the causes from the live source levels
    //   internal resets leave the causes sticky

    // Reset output timing
    //   internal sources reach the output one edge later
    //   pin adds two synchroniser edges before that
    //   output is high throughout power-on reset
    //   output is a flop, so it never glitches

    // Hazards
    //   protected control writes made while a reset is pending are lost
    //   a key written during a pin reset still commits
    //   a new cause in the clear cycle stays set
    //   writing the clear bit as zero withdraws the request
    //   software must never read-modify-write the key address
    //   the status seen there is not the key just written

    // Interrupt path
    //   each source rise sets one status bit
    //   a rise in the clear cycle wins over the clear
    //   the output is a level while an enabled bit is set
    //   enable bits reset to zero, so the output starts low
    //   the edge memory resets to the idle level of the sources
    //   so no false rise follows reset

    // Clock domains
    //   everything runs on pclk
    //   only the reset pin comes from outside
    //   the pin passes two flops before any logic reads it
    //   internal sources already sit on pclk

    // Limits
    //   address width is a parameter, decode uses bits 15 to 2
    //   only the low strobe matters for writes
    //   no clock enable, every flop runs each edge
    //   the block itself is never reset by its own output

    // Synchroniser for the reset pin
    logic pin_sync1;
    logic pin_sync2;
    // Register state
    logic [rcpl_pkg::CTRL_W-1:0] ctrl_written;
    logic clear_request;
    logic [rcpl_pkg::CAUSE_W-1:0] cause_flags;
    logic [rcpl_pkg::CAUSE_W-1:0] src_prev;
    logic [rcpl_pkg::CAUSE_W-1:0] irq_status;
    logic [rcpl_pkg::CAUSE_W-1:0] irq_enable;
    // Decode and combinational helpers
    logic [13:0] reg_index;
    logic aligned;
    logic hit_cause;
    logic hit_ctrl;
    logic hit_key;
    logic hit_istat;
    logic hit_ien;
    logic hit_iclr;
    logic mapped;
    logic setup;
    logic wr;
    logic wr_low;
    logic key_wr;
    logic pin_active;
    logic [rcpl_pkg::CAUSE_W-1:0] src_vec;
    logic [rcpl_pkg::CAUSE_W-1:0] internal_src;
    logic [rcpl_pkg::CAUSE_W-1:0] src_rise;
    logic any_internal;
    logic next_sys_reset;
    logic [31:0] next_rdata;

    // Source vector in cause flag order
    assign src_vec = {src_flash_standby, src_bad_trim, src_trim_fault, src_voltage_two,
                      src_voltage_one, src_clock_fault, src_watchdog}; // [R10]
    // Bad trim status is a flag but not a reset source
    assign internal_src = {src_flash_standby, 1'b0, src_trim_fault, src_voltage_two,
                           src_voltage_one, src_clock_fault, src_watchdog}; // [R1]
    assign any_internal = |internal_src;
    assign src_rise = src_vec & ~src_prev;

    // Pin counts only while the committed disable is zero
    assign pin_active = ~pin_sync2 & ~pin_disable_committed; // [R2]
    assign next_sys_reset = pin_active | any_internal; // [R14]

    // APB address decode, word aligned
    assign reg_index = paddr[15:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign hit_cause = aligned && (reg_index == rcpl_pkg::IDX_CAUSE);
    assign hit_ctrl = aligned && (reg_index == rcpl_pkg::IDX_CTRL);
    assign hit_key = aligned && (reg_index == rcpl_pkg::IDX_KEY);
    assign hit_istat = aligned && (reg_index == rcpl_pkg::IDX_IRQ_STATUS);
    assign hit_ien = aligned && (reg_index == rcpl_pkg::IDX_IRQ_ENABLE);
    assign hit_iclr = aligned && (reg_index == rcpl_pkg::IDX_IRQ_CLEAR);
    assign mapped = hit_cause | hit_ctrl | hit_key | hit_istat | hit_ien | hit_iclr;
    assign setup = psel & ~penable;
    // Zero wait state slave
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite & mapped;
    assign wr_low = wr & pstrb[0];
    // Key register takes plain writes only; it has no readable copy to merge
    assign key_wr = wr_low & hit_key; // [R6]

    // Read data multiplexer
    always_comb begin
        next_rdata = rcpl_pkg::RDATA_RESET;
        if (hit_cause) begin
            next_rdata[rcpl_pkg::CAUSE_W-1:0] = cause_flags; // [R13]
        end else if (hit_ctrl) begin
            next_rdata[rcpl_pkg::CTRL_W-1:0] = ctrl_written; // [R9]
        end else if (hit_key) begin
            next_rdata[rcpl_pkg::CTRL_PIN_BIT] = pin_disable_committed; // [R7]
            next_rdata[rcpl_pkg::CTRL_REGION_BIT] = reset_region_committed;
            next_rdata[rcpl_pkg::CTRL_VECTOR_BIT] = reset_vector_committed;
        end else if (hit_istat) begin
            next_rdata[rcpl_pkg::CAUSE_W-1:0] = irq_status;
        end else if (hit_ien) begin
            next_rdata[rcpl_pkg::CAUSE_W-1:0] = irq_enable;
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= rcpl_pkg::RDATA_RESET;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? rcpl_pkg::RDATA_RESET : next_rdata;
            pslverr <= ~mapped;
        end
    end

    // Two flip-flop synchroniser for the reset pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync1 <= 1'b1;
            pin_sync2 <= 1'b1;
        end else begin
            pin_sync1 <= reset_pin_n;
            pin_sync2 <= pin_sync1;
        end
    end

    // Combined system reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset <= 1'b1;
        end else begin
            sys_reset <= next_sys_reset; // [R14]
        end
    end

    // Written copy of protected control, wiped by any reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_written <= rcpl_pkg::CTRL_RESET;
        end else if (next_sys_reset) begin
            ctrl_written <= rcpl_pkg::CTRL_RESET; // [R4]
        end else if (wr_low && hit_ctrl) begin
            ctrl_written <= pwdata[rcpl_pkg::CTRL_W-1:0];
        end
    end

    // Committed pin disable, cleared by power-on only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_disable_committed <= 1'b0; // [R4]
        end else if (key_wr && pwdata[7:0] == rcpl_pkg::KEY_PIN) begin
            pin_disable_committed <= ctrl_written[rcpl_pkg::CTRL_PIN_BIT]; // [R3] [R5]
        end
    end

    // Committed region and vector selects
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_region_committed <= 1'b0;
            reset_vector_committed <= 1'b0;
        end else if (key_wr && pwdata[7:0] == rcpl_pkg::KEY_REGION) begin
            reset_region_committed <= ctrl_written[rcpl_pkg::CTRL_REGION_BIT]; // [R5]
            reset_vector_committed <= ctrl_written[rcpl_pkg::CTRL_VECTOR_BIT];
        end
    end

    // Flag clear request, consumed by the clear key
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_request <= 1'b0;
        end else if (pin_active) begin
            clear_request <= 1'b0;
        end else if (key_wr && pwdata[7:0] == rcpl_pkg::KEY_FLAGS) begin
            clear_request <= 1'b0; // [R12]
        end else if (wr_low && hit_cause) begin
            clear_request <= pwdata[rcpl_pkg::CAUSE_CLEAR_BIT];
        end
    end

    // Sticky cause flags; a new cause wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_flags <= rcpl_pkg::CAUSE_RESET;
        end else if (pin_active) begin
            cause_flags <= src_vec; // [R11]
        end else if (key_wr && pwdata[7:0] == rcpl_pkg::KEY_FLAGS && clear_request) begin
            cause_flags <= src_vec; // [R12]
        end else begin
            cause_flags <= cause_flags | src_vec; // [R10] [R14]
        end
    end

    // Previous source levels for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev <= rcpl_pkg::CAUSE_RESET;
        end else begin
            src_prev <= src_vec;
        end
    end

    // Interrupt status: set on source rise, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= rcpl_pkg::CAUSE_RESET;
        end else if (wr_low && hit_iclr) begin
            irq_status <= (irq_status & ~pwdata[rcpl_pkg::CAUSE_W-1:0]) | src_rise;
        end else begin
            irq_status <= irq_status | src_rise;
        end
    end

    // Interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= rcpl_pkg::CAUSE_RESET;
        end else if (wr_low && hit_ien) begin
            irq_enable <= pwdata[rcpl_pkg::CAUSE_W-1:0];
        end
    end

    // Level interrupt output
    assign irq = |(irq_status & irq_enable);

endmodule

// File: verification/rcpl_assertions.sv
// Checker for the reset cause and pin lock block
`timescale 1ns/1ps
module rcpl_assertions #(
    parameter int ADDR_W = 16
) (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Reset sources
    input wire logic reset_pin_n,
    input wire logic src_watchdog,
    input wire logic src_clock_fault,
    input wire logic src_voltage_one,
    input wire logic src_voltage_two,
    input wire logic src_trim_fault,
    input wire logic src_flash_standby,
    // Results
    input wire logic sys_reset,
    input wire logic pin_disable_committed,
    input wire logic reset_region_committed,
    input wire logic reset_vector_committed
);
    localparam logic [ADDR_W-1:0] A_CAUSE = ADDR_W'({rcpl_pkg::IDX_CAUSE, 2'b00});
    localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'({rcpl_pkg::IDX_CTRL, 2'b00});
    localparam logic [ADDR_W-1:0] A_KEY = ADDR_W'({rcpl_pkg::IDX_KEY, 2'b00});
    // Decoded source and bus events
    wire logic src_any = src_watchdog | src_clock_fault | src_voltage_one
        | src_voltage_two | src_trim_fault | src_flash_standby;
    wire logic rd = psel & penable & ~pwrite;
    wire logic key_wr = psel & penable & pwrite & (paddr == A_KEY);
    wire logic kpin = key_wr & (pwdata[7:0] == rcpl_pkg::KEY_PIN);
    wire logic kreg = key_wr & (pwdata[7:0] == rcpl_pkg::KEY_REGION);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd_key;
        rd && paddr == A_KEY;
    endsequence
    sequence s_pin_active;
        (!reset_pin_n && !pin_disable_committed) [*4];
    endsequence
    property p_src_reset; src_any |=> sys_reset; endproperty
    a_src_reset: assert property (p_src_reset) else $error("source gave no reset");
    property p_idle; (!src_any && reset_pin_n) [*5] |-> !sys_reset; endproperty
    a_idle: assert property (p_idle) else $error("reset without source");
    property p_pin_honour; s_pin_active |-> sys_reset; endproperty
    a_pin_honour: assert property (p_pin_honour) else $error("pin reset lost");
    property p_pin_ignored; (pin_disable_committed && !src_any) [*4] |-> !sys_reset; endproperty
    a_pin_ignored: assert property (p_pin_ignored) else $error("disabled pin reset");
    property p_pin_lock;
        $changed(pin_disable_committed) |-> $past(kpin) || $past(kpin, 2);
    endproperty
    a_pin_lock: assert property (p_pin_lock) else $error("pin bit moved unkeyed");
    property p_region_lock;
        $changed(reset_region_committed) || $changed(reset_vector_committed)
            |-> $past(kreg) || $past(kreg, 2);
    endproperty
    a_region_lock: assert property (p_region_lock) else $error("region moved");
    property p_status_read;
        s_rd_key |-> prdata[31:3] == 29'h0 && prdata[0] == $past(pin_disable_committed)
            && prdata[1] == $past(reset_region_committed)
            && prdata[2] == $past(reset_vector_committed);
    endproperty
    a_status_read: assert property (p_status_read) else $error("bad status read");
    property p_ctrl_zero; rd && paddr == A_CTRL |-> prdata[31:3] == 29'h0; endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("control upper bits set");
    property p_cause_zero; rd && paddr == A_CAUSE |-> prdata[31:7] == 25'h0; endproperty
    a_cause_zero: assert property (p_cause_zero) else $error("cause bit 7 set");
endmodule
bind rcpl_top rcpl_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);

// File: verification/rcpl_sources.sv
// Model of the on-chip reset sources and the reset pin
`timescale 1ns/1ps
module rcpl_sources (
    // Clock and requests
    input wire logic pclk,
    input wire logic [6:0] req,
    input wire logic pin_low,
    // Source levels in cause bit order, pin
    output logic [6:0] src,
    output logic reset_pin_n
);
    // Internal sources move on the system clock
    always_ff @(posedge pclk) src <= req;
    assign reset_pin_n = ~pin_low;
endmodule

// File: verification/reset_cause_and_pin_lock_bench.sv
// Self-checking bench for the reset cause and pin lock block
`timescale 1ns/1ps
module reset_cause_and_pin_lock_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin_low = 0, pin_n;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h0000_0030;
    logic [6:0] req = 7'h0, src, flags;
    logic pready, pslverr, sys_reset, pin_dis, region, vector, irq;
    logic [32:0] q[$];
    int err_count = 0, compares = 0, i, n;
    localparam logic [15:0] A_CAUSE = {rcpl_pkg::IDX_CAUSE, 2'b00};
    localparam logic [15:0] A_CTRL = {rcpl_pkg::IDX_CTRL, 2'b00};
    localparam logic [15:0] A_KEY = {rcpl_pkg::IDX_KEY, 2'b00};
    localparam logic [15:0] A_IEN = {rcpl_pkg::IDX_IRQ_ENABLE, 2'b00};
    localparam logic [15:0] A_ICLR = {rcpl_pkg::IDX_IRQ_CLEAR, 2'b00};
    rcpl_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_pin_n(pin_n), .src_watchdog(src[0]),
        .src_clock_fault(src[1]), .src_voltage_one(src[2]), .src_voltage_two(src[3]),
        .src_trim_fault(src[4]), .src_bad_trim(src[5]), .src_flash_standby(src[6]),
        .sys_reset(sys_reset), .pin_disable_committed(pin_dis),
        .reset_region_committed(region), .reset_vector_committed(vector), .irq(irq));
    rcpl_sources model (.pclk(pclk), .req(req), .pin_low(pin_low), .src(src),
        .reset_pin_n(pin_n));
    initial forever #4 pclk = ~pclk;
    // Pseudo-random steps
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] ex, input logic [32:0] got);
        compares++;
        if (got !== ex) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // One APB transfer; a read notes its expected error bit and data first
    task automatic bus(input logic w, input logic [15:0] a, input logic [32:0] d);
        if (!w) q.push_back(d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d[31:0];
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            err_count++;
            end_of_test();
        end
        @(posedge pclk);
    endtask
    // Compares each completed read against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1)
            chk($sformatf("read %h", paddr), q.pop_front(), {pslverr, prdata});
    end
    initial begin
        tick(12);
        presetn <= 1'b1;
        tick(1);
        bus(0, A_CAUSE, 33'h0);
        bus(0, A_KEY, 33'h0);
        bus(0, 16'h0004, 33'h1_0000_0000);
        bus(1, A_CTRL, 33'h0_ffff_ffff);
        bus(0, A_CTRL, 33'h7);
        for (i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            if (rnd[7:0] != rcpl_pkg::KEY_PIN && rnd[7:0] != rcpl_pkg::KEY_REGION)
                bus(1, A_KEY, {1'b0, rnd});
        end
        bus(0, A_KEY, 33'h0);
        bus(1, A_KEY, 33'(rcpl_pkg::KEY_PIN));
        bus(0, A_KEY, 33'h1);
        bus(1, A_KEY, 33'(rcpl_pkg::KEY_REGION));
        bus(0, A_KEY, 33'h7);
        pin_low <= 1'b1;
        tick(6);
        chk("sys_reset", 33'h0, 33'(sys_reset));
        pin_low <= 1'b0;
        $display("test keys done");
        bus(1, A_IEN, 33'h1);
        flags = 7'h0;
        for (i = 0; i < 7; i++) begin
            req <= 7'(1 << i);
            rnd = xs(rnd);
            tick(3 + int'(rnd[1:0]));
            chk("sys_reset", 33'(i != 5), 33'(sys_reset));
            chk("irq", 33'(i == 0), 33'(irq));
            req <= 7'h0;
            tick(3);
            flags[i] = 1'b1;
            bus(0, A_CAUSE, {26'h0, flags});
            bus(1, A_ICLR, 33'h7f);
            chk("irq", 33'h0, 33'(irq));
        end
        bus(0, A_CTRL, 33'h0);
        bus(0, A_KEY, 33'h7);
        bus(1, A_KEY, 33'(rcpl_pkg::KEY_FLAGS));
        bus(0, A_CAUSE, 33'h7f);
        bus(1, A_CAUSE, 33'h80);
        bus(0, A_CAUSE, 33'h7f);
        bus(1, A_KEY, 33'(rcpl_pkg::KEY_FLAGS));
        bus(0, A_CAUSE, 33'h0);
        $display("test causes done");
        presetn <= 1'b0;
        tick(2);
        chk("sys_reset", 33'h1, 33'(sys_reset));
        presetn <= 1'b1;
        tick(1);
        bus(0, A_KEY, 33'h0);
        bus(1, A_CTRL, 33'h6);
        bus(1, A_KEY, 33'(rcpl_pkg::KEY_REGION));
        req <= 7'h1;
        tick(3);
        req <= 7'h0;
        tick(3);
        pin_low <= 1'b1;
        tick(6);
        chk("sys_reset", 33'h1, 33'(sys_reset));
        pin_low <= 1'b0;
        tick(6);
        bus(0, A_CAUSE, 33'h0);
        bus(0, A_KEY, 33'h6);
        $display("test pin reset done");
        end_of_test();
    end
endmodule
